// file: cit0_link_dev.sv
// Card-side I/O line controller: character framing, error repeat and command header tracking
// Operation
// - Transmit only after finding line high
// - Convention maps logic one to line level
// - Ten-bit frame: start, eight data, even parity
// - Confirm start bit before 0.7 etu
// - Sample bit n at n+0.5 etu
// - Guard time keeps both sides receiving, line high
// - Bytes least significant first in direct convention, most significant first in inverse
// - Low impedance: transmitter drives whole frame
// - Next transmitter holds line high when idle
// - Start edges at least 12 etu apart
// - Card character within work waiting limit
// - Header answered by procedure or status byte
// - Parity error pulls line low 10.5 etu
// - Transmitter checks at 11 etu, resends
// - Error signalling and repeat always used here
`timescale 1ns/100ps
`default_nettype none
module cit0_link_dev
  import cit0_pkg::*;
#(
  parameter int NULL_MARGIN_ETU = DEF_NULL_MARGIN_ETU
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  // I/O line pin
  input  wire logic        io_i,
  output logic             io_o,
  output logic             io_oe_o,
  // Link configuration
  input  wire logic        inverse_conv_i,
  input  wire logic        low_imp_i,
  input  wire logic [11:0] clock_rate_factor_i,
  input  wire logic [5:0]  baud_rate_factor_i,
  input  wire logic [7:0]  wait_integer_i,
  // Bytes to send
  input  wire logic        tx_valid_i,
  input  wire logic [7:0]  tx_data_i,
  input  wire logic        tx_last_i,
  output logic             tx_ready_o,
  // Bytes received
  output logic             rx_valid_o,
  output logic [7:0]       rx_data_o,
  output logic             rx_header_o,
  output logic             header_done_o,
  output logic [7:0]       instruction_byte_o,
  // Status
  output logic             reply_due_o,
  output logic             rx_parity_err_o,
  output logic             tx_retry_o,
  output logic             null_sent_o
);

  // Margin must leave room before the shortest limit of 960 etu
  if (NULL_MARGIN_ETU < 1 || NULL_MARGIN_ETU > 900) begin : g_bad_margin
    $error("NULL_MARGIN_ETU out of range");
  end

  localparam logic [24:0] NULL_MARGIN_H = 25'(2 * NULL_MARGIN_ETU);

  // Frame levels, start bit first; parity taken over the logical bits
  function automatic logic [9:0] cit0_encode(input logic [7:0] b, input logic inv);
    logic [7:0] ord;
    ord = inv ? {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]} : b;
    cit0_encode = {(^b) ^ inv, inv ? ~ord : ord, 1'b0};
  endfunction : cit0_encode

  // Logical byte from nine sampled levels (data then parity)
  function automatic logic [7:0] cit0_decode(input logic [8:0] lvl, input logic inv);
    logic [7:0] d;
    d = inv ? ~lvl[7:0] : lvl[7:0];
    cit0_decode = inv ? {d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]} : d;
  endfunction : cit0_decode

  // Pin synchroniser; only line_s and line_prev_ff feed logic
  logic sync1_ff;
  logic line_s;
  logic line_prev_ff;
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sync1_ff     <= 1'b1;
      line_s       <= 1'b1;
      line_prev_ff <= 1'b1;
    end else begin
      sync1_ff     <= io_i;
      line_s       <= sync1_ff;
      line_prev_ff <= line_s;
    end
  end

  // State
  cit0_state_e state_ff, nxt_state;
  logic [11:0] acc_ff, nxt_acc;
  logic [4:0]  hcnt_ff, nxt_hcnt;
  logic [24:0] wait_ff, nxt_wait;
  logic [9:0]  frame_ff, nxt_frame;
  logic [8:0]  lvl_ff, nxt_lvl;
  logic        err_ff, nxt_err;
  logic        retry_ff, nxt_retry;
  logic        reply_ff, nxt_reply;
  logic        hdr_ph_ff, nxt_hdr_ph;
  logic [2:0]  hdr_cnt_ff, nxt_hdr_cnt;
  logic [7:0]  instr_ff, nxt_instr;
  logic        oe_ff, nxt_oe;
  logic        out_ff, nxt_out;
  logic        rxv_ff, nxt_rxv;
  logic [7:0]  rxd_ff, nxt_rxd;
  logic        rxh_ff, nxt_rxh;
  logic        hdone_ff, nxt_hdone;
  logic        perr_ff, nxt_perr;
  logic        retp_ff, nxt_retp;
  logic        nulp_ff, nxt_nulp;

  // Helper terms
  logic [12:0] sum;
  logic        tick;
  logic [4:0]  nh;
  logic        fall;
  logic        start_ok;
  logic [24:0] limit_h;
  logic        null_due;
  logic        par_bad;

  // Half-etu tick from a fractional accumulator: step 2*D against F
  assign sum  = {1'b0, acc_ff} + {6'h00, baud_rate_factor_i, 1'b0};
  assign tick = sum >= {1'b0, clock_rate_factor_i};
  assign nh   = hcnt_ff + 5'h01;
  assign fall = line_prev_ff & ~line_s;
  // Sync delay shifts the time origin by a few clocks, far inside 0.2 etu
  assign start_ok = line_s && (hcnt_ff >= (retry_ff ? H_RETRY_GAP : H_CHAR_GAP));
  assign limit_h  = 25'({6'h00, wait_integer_i} * {8'h00, baud_rate_factor_i}) * WAIT_HALF_PER_UNIT;
  assign null_due = reply_ff && (wait_ff >= limit_h - NULL_MARGIN_H);
  assign par_bad  = (^lvl_ff) ^ inverse_conv_i;
  assign tx_ready_o = (state_ff == ST_IDLE) && start_ok && !retry_ff && !null_due;

  // Next-state logic
  always_comb begin
    nxt_state   = state_ff;
    nxt_acc     = tick ? 12'(sum - {1'b0, clock_rate_factor_i}) : sum[11:0];
    nxt_hcnt    = (tick && hcnt_ff != H_SAT) ? nh : hcnt_ff;
    nxt_wait    = (tick && wait_ff != {25{1'b1}}) ? wait_ff + 25'h0000001 : wait_ff;
    nxt_frame   = frame_ff;
    nxt_lvl     = lvl_ff;
    nxt_err     = err_ff;
    nxt_retry   = retry_ff;
    nxt_reply   = reply_ff;
    nxt_hdr_ph  = hdr_ph_ff;
    nxt_hdr_cnt = hdr_cnt_ff;
    nxt_instr   = instr_ff;
    nxt_oe      = oe_ff;
    nxt_out     = out_ff;
    nxt_rxv     = 1'b0;
    nxt_rxd     = rxd_ff;
    nxt_rxh     = rxh_ff;
    nxt_hdone   = 1'b0;
    nxt_perr    = 1'b0;
    nxt_retp    = 1'b0;
    nxt_nulp    = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        // Outside the header phase the card may hold the line high as next sender (low impedance only)
        nxt_oe  = low_imp_i && !hdr_ph_ff;
        nxt_out = 1'b1;
        if (fall) begin
          nxt_state = ST_RX;
          nxt_acc   = RST_ACC;
          nxt_hcnt  = 5'h00;
          nxt_wait  = RST_WAIT;
          nxt_err   = 1'b0;
          nxt_oe    = 1'b0;
        end else if (start_ok && (retry_ff || null_due || tx_valid_i)) begin
          nxt_state = ST_TX;
          nxt_acc   = RST_ACC;
          nxt_hcnt  = 5'h00;
          nxt_wait  = RST_WAIT;
          nxt_err   = 1'b0;
          nxt_oe    = 1'b1; // Start bit is always driven low
          nxt_out   = 1'b0;
          if (retry_ff) begin
            nxt_retry = 1'b0;
          end else if (null_due) begin
            nxt_frame = cit0_encode(NULL_BYTE, inverse_conv_i);
            nxt_nulp  = 1'b1;
          end else begin
            nxt_frame = cit0_encode(tx_data_i, inverse_conv_i);
            nxt_reply = 1'b0;
            if (tx_last_i) begin
              nxt_hdr_ph  = 1'b1;
              nxt_hdr_cnt = 3'h0;
            end
          end
        end
      end
      ST_RX: begin
        if (tick) begin
          if (nh == H_CONFIRM && line_s) begin
            nxt_state = ST_IDLE;
          end else if (nh >= H_FIRST_DATA && nh <= H_LAST_BIT && nh[0]) begin
            nxt_lvl = {line_s, lvl_ff[8:1]};
          end else if (nh == H_GUARD) begin
            if (par_bad) begin
              nxt_err  = 1'b1;
              nxt_perr = 1'b1;
            end else begin
              nxt_rxv = 1'b1;
              nxt_rxd = cit0_decode(lvl_ff, inverse_conv_i);
              nxt_rxh = hdr_ph_ff;
              if (hdr_ph_ff) begin
                if (hdr_cnt_ff == INSTR_POS) begin
                  nxt_instr = cit0_decode(lvl_ff, inverse_conv_i);
                end
                if (hdr_cnt_ff == HEADER_LEN - 3'h1) begin
                  nxt_hdone   = 1'b1;
                  nxt_reply   = 1'b1;
                  nxt_hdr_ph  = 1'b0;
                  nxt_hdr_cnt = 3'h0;
                end else begin
                  nxt_hdr_cnt = hdr_cnt_ff + 3'h1;
                end
              end
            end
          end else if (nh == H_ERR_ON && err_ff) begin
            nxt_oe  = 1'b1;
            nxt_out = 1'b0;
          end else if (nh == H_RX_DONE && !err_ff) begin
            nxt_state = ST_IDLE;
          end else if (nh == H_ERR_OFF) begin
            nxt_oe    = 1'b0; // Low for 1.5 etu, within 1 to 2 etu
            nxt_out   = 1'b1;
            nxt_err   = 1'b0;
            nxt_state = ST_IDLE;
          end
        end
      end
      ST_TX: begin
        if (tick) begin
          if (nh < H_GUARD && !nh[0]) begin
            nxt_out = frame_ff[nh[4:1]];
            nxt_oe  = low_imp_i || !frame_ff[nh[4:1]];
          end else if (nh == H_GUARD) begin
            nxt_oe  = 1'b0; // Released so the receiver can signal an error
            nxt_out = 1'b1;
          end else if (nh == H_TX_CHECK && !line_s) begin
            nxt_retry = 1'b1;
            nxt_retp  = 1'b1;
          end else if (nh == H_CHAR_GAP) begin
            nxt_state = ST_IDLE;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_ff   <= ST_IDLE;
      acc_ff     <= RST_ACC;
      hcnt_ff    <= H_SAT;
      wait_ff    <= RST_WAIT;
      frame_ff   <= 10'h3ff;
      lvl_ff     <= 9'h000;
      err_ff     <= 1'b0;
      retry_ff   <= 1'b0;
      reply_ff   <= 1'b0;
      hdr_ph_ff  <= 1'b1;
      hdr_cnt_ff <= 3'h0;
      instr_ff   <= 8'h00;
      oe_ff      <= 1'b0;
      out_ff     <= 1'b1;
      rxv_ff     <= 1'b0;
      rxd_ff     <= 8'h00;
      rxh_ff     <= 1'b0;
      hdone_ff   <= 1'b0;
      perr_ff    <= 1'b0;
      retp_ff    <= 1'b0;
      nulp_ff    <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      acc_ff     <= nxt_acc;
      hcnt_ff    <= nxt_hcnt;
      wait_ff    <= nxt_wait;
      frame_ff   <= nxt_frame;
      lvl_ff     <= nxt_lvl;
      err_ff     <= nxt_err;
      retry_ff   <= nxt_retry;
      reply_ff   <= nxt_reply;
      hdr_ph_ff  <= nxt_hdr_ph;
      hdr_cnt_ff <= nxt_hdr_cnt;
      instr_ff   <= nxt_instr;
      oe_ff      <= nxt_oe;
      out_ff     <= nxt_out;
      rxv_ff     <= nxt_rxv;
      rxd_ff     <= nxt_rxd;
      rxh_ff     <= nxt_rxh;
      hdone_ff   <= nxt_hdone;
      perr_ff    <= nxt_perr;
      retp_ff    <= nxt_retp;
      nulp_ff    <= nxt_nulp;
    end
  end

  // Outputs
  assign io_o               = out_ff;
  assign io_oe_o            = oe_ff;
  assign rx_valid_o         = rxv_ff;
  assign rx_data_o          = rxd_ff;
  assign rx_header_o        = rxh_ff;
  assign header_done_o      = hdone_ff;
  assign instruction_byte_o = instr_ff;
  assign reply_due_o        = reply_ff;
  assign rx_parity_err_o    = perr_ff;
  assign tx_retry_o         = retp_ff;
  assign null_sent_o        = nulp_ff;

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  logic tx_go;
  assign tx_go = (state_ff == ST_IDLE) && (nxt_state == ST_TX);

  AST_TX_LINE_HIGH: assert property (tx_go |-> line_s)
    else $error("transmission started on a low line");
  AST_TX_START_LOW: assert property (tx_go |=> io_oe_o && !io_o && state_ff == ST_TX)
    else $error("start bit not driven low");
  AST_TX_SPACING: assert property (tx_go |-> hcnt_ff >= 5'h18)
    else $error("start edges closer than 12 etu");
  AST_RETRY_GAP: assert property (tx_go && retry_ff |-> hcnt_ff >= 5'h1c)
    else $error("repeat sent too early");
  AST_RX_PARITY: assert property (rx_valid_o |-> $past(par_bad) == 1'b0)
    else $error("byte delivered with bad parity");
  AST_ERR_PULSE: assert property (state_ff == ST_RX && tick && nh == 5'h15 && err_ff |=> io_oe_o && !io_o)
    else $error("parity error not signalled at 10.5 etu");
  AST_ERR_WINDOW: assert property (state_ff == ST_RX && io_oe_o |-> hcnt_ff >= 5'h15 && hcnt_ff <= 5'h18)
    else $error("error pulse outside its window");
  AST_LOWIMP_DRIVE: assert property (low_imp_i && state_ff == ST_TX && hcnt_ff >= 5'h01 && hcnt_ff < 5'h14 |-> io_oe_o)
    else $error("line not driven during low impedance frame");
  AST_GUARD_FREE: assert property (state_ff == ST_TX && hcnt_ff >= 5'h15 && hcnt_ff < 5'h18 |-> !io_oe_o)
    else $error("transmitter drives during guard time");
  AST_REPLY_DUE: assert property (header_done_o |-> reply_due_o)
    else $error("header not followed by a due reply");
  AST_WAIT_LIMIT: assert property (reply_due_o |-> wait_ff <= limit_h)
    else $error("work waiting limit exceeded");

endmodule : cit0_link_dev
`default_nettype wire

// file: cit0_link_dev_tb_top.sv
// Testbench for the card-side character link against a terminal model
`timescale 1ns/100ps
`default_nettype none
module cit0_link_dev_tb_top;
  import cit0_pkg::*;

  logic       clock_i        = 1'b0;
  logic       reset_i        = 1'b1;
  logic       inverse_conv_i = 1'b0;
  logic       low_imp_i      = 1'b0;
  logic       tx_valid_i     = 1'b0;
  logic       tx_last_i      = 1'b0;
  logic [7:0] tx_data_i      = 8'h00;
  logic [7:0] wait_integer_i = 8'h0a;
  logic [11:0] clock_rate_factor_i = 12'h008;
  logic [5:0]  baud_rate_factor_i  = 6'h01;
  logic       io_o, io_oe_o, tx_ready_o, rx_valid_o, rx_header_o, header_done_o;
  logic       reply_due_o, rx_parity_err_o, tx_retry_o, null_sent_o, term_low;
  logic [7:0] rx_data_o, instruction_byte_o;
  wire logic  line;
  logic [7:0] rxd[$];
  logic       rxh[$];
  int         hd_cnt, pe_cnt, re_cnt, nu_cnt;
  int         errors  = 0;
  int         checked = 0;

  // 20 MHz card clock
  always #25 clock_i = ~clock_i;

  // Resolved line: card drives when enabled, otherwise pull-up, terminal may pull low
  assign line = (io_oe_o === 1'b1 ? io_o : 1'b1) & ~term_low;

  // Etu shortened to 8 clocks so the waiting limit fits the run
  cit0_link_dev #(.NULL_MARGIN_ETU(32)) i_dut (
    .clock_i(clock_i), .reset_i(reset_i), .io_i(line), .io_o(io_o), .io_oe_o(io_oe_o),
    .inverse_conv_i(inverse_conv_i), .low_imp_i(low_imp_i), .clock_rate_factor_i(clock_rate_factor_i),
    .baud_rate_factor_i(baud_rate_factor_i), .wait_integer_i(wait_integer_i), .tx_valid_i(tx_valid_i),
    .tx_data_i(tx_data_i), .tx_last_i(tx_last_i), .tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o),
    .rx_data_o(rx_data_o), .rx_header_o(rx_header_o), .header_done_o(header_done_o),
    .instruction_byte_o(instruction_byte_o), .reply_due_o(reply_due_o),
    .rx_parity_err_o(rx_parity_err_o), .tx_retry_o(tx_retry_o), .null_sent_o(null_sent_o));

  cit0_term_model #(.ETU(8)) i_term (
    .clock_i(clock_i), .line_i(line), .inverse_i(inverse_conv_i), .drv_low_o(term_low));

  // Collect received bytes and count single-cycle pulses
  always @(posedge clock_i) begin
    if (rx_valid_o === 1'b1) begin
      rxd.push_back(rx_data_o);
      rxh.push_back(rx_header_o);
    end
    if (header_done_o === 1'b1) hd_cnt++;
    if (rx_parity_err_o === 1'b1) pe_cnt++;
    if (tx_retry_o === 1'b1) re_cnt++;
    if (null_sent_o === 1'b1) nu_cnt++;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  // Sync flops need line high for a few edges after release
  task automatic do_reset();
    @(posedge clock_i) reset_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    rxd.delete();
    rxh.delete();
    i_term.rxq.delete();
    {hd_cnt, pe_cnt, re_cnt, nu_cnt} = '0;
  endtask : do_reset

  // Terminal sends a five byte header, one byte optionally with bad parity
  task automatic send_header(input logic [39:0] h, input int bad_at);
    for (int i = 0; i < 5; i++) i_term.send_char(h[39-8*i -: 8], i == bad_at);
    check("header count", rxd.size(), 5);
    for (int i = 0; i < 5; i++) begin
      check("header byte", rxd[i], h[39-8*i -: 8]);
      check("header flag", rxh[i], 1'b1);
    end
    check("header done", hd_cnt, 1);
    check("instruction", instruction_byte_o, h[31:24]);
    check("reply due", reply_due_o, 1'b1);
    rxd.delete();
    rxh.delete();
  endtask : send_header

  // Card byte: hold valid until ready is seen before an edge
  task automatic card_send(input logic [7:0] b, input logic last);
    int t;
    t = 0;
    @(posedge clock_i);
    tx_valid_i <= 1'b1;
    tx_data_i <= b;
    tx_last_i <= last;
    while (t < 3000) begin
      @(negedge clock_i);
      if (tx_ready_o === 1'b1) break;
      t++;
    end
    check("tx accepted", t < 3000, 1'b1);
    @(posedge clock_i);
    tx_valid_i <= 1'b0;
  endtask : card_send

  task automatic wait_q(input logic [7:0] exp);
    int t;
    t = 0;
    while (i_term.rxq.size() == 0 && t < 3000) begin
      @(posedge clock_i);
      t++;
    end
    check("card byte", i_term.rxq.pop_front(), exp);
    check("card parity", i_term.par_bad, 0);
  endtask : wait_q

  // Watchdog cuts a hang short
  initial begin
    repeat (40000) @(posedge clock_i);
    errors++;
    end_sim();
  end

  initial begin
    int t;
    do_reset();
    // Header with a parity error in mid-sequence
    send_header(40'ha0_a4_00_00_02, 2);
    check("parity err pulse", pe_cnt, 1);
    check("error pulse length", i_term.err_low inside {[8:16]}, 1'b1);
    $display("test header done");
    // Echo, data, one-byte ack, nacked 6C pair, resent header, 61 pair, fetch header, 90 00
    card_send(8'ha4, 1'b0);
    wait_q(8'ha4);
    check("start spacing", i_term.last_gap >= 96, 1'b1);
    check("reply cleared", reply_due_o, 1'b0);
    i_term.send_char(8'h5a, 1'b0);
    i_term.send_char(8'h81, 1'b0);
    check("data bytes", {rxd[0], rxd[1]}, 16'h5a81);
    check("data flags", {rxh[0], rxh[1]}, 2'b00);
    card_send(8'h5b, 1'b0);
    wait_q(8'h5b);
    i_term.send_char(8'h3c, 1'b0);
    check("ack data count", rxd.size(), 3);
    check("ack data byte", rxd[2], 8'h3c);
    @(posedge clock_i) i_term.nack_next <= 1'b1;
    card_send(8'h6c, 1'b0);
    wait_q(8'h6c);
    check("retry pulse", re_cnt, 1);
    check("repeat spacing", i_term.last_gap >= 112, 1'b1);
    card_send(8'h08, 1'b1);
    wait_q(8'h08);
    rxd.delete();
    rxh.delete();
    hd_cnt = 0;
    send_header(40'ha0_a4_00_00_08, -1);
    card_send(8'h61, 1'b0);
    wait_q(8'h61);
    card_send(8'h10, 1'b1);
    wait_q(8'h10);
    hd_cnt = 0;
    send_header(40'ha0_c0_00_00_10, -1);
    card_send(8'h90, 1'b0);
    wait_q(8'h90);
    card_send(8'h00, 1'b1);
    wait_q(8'h00);
    rxh.delete();
    i_term.send_char(8'ha0, 1'b0);
    check("new header", rxh[0], 1'b1);
    $display("test exchange done");
    // A short low blocks the card transmitter, then is dropped as a false start
    do_reset();
    @(posedge clock_i) i_term.hold_low <= 1'b1;
    repeat (3) @(posedge clock_i);
    check("ready low line", tx_ready_o, 1'b0);
    i_term.hold_low <= 1'b0;
    repeat (110) @(posedge clock_i);
    check("ready high line", tx_ready_o, 1'b1);
    $display("test line busy done");
    // Inverse convention, low impedance, wait byte; etu still 8 clocks from 16 over 2
    inverse_conv_i <= 1'b1;
    low_imp_i <= 1'b1;
    wait_integer_i <= 8'h01;
    clock_rate_factor_i <= 12'h010;
    baud_rate_factor_i <= 6'h02;
    do_reset();
    send_header(40'h00_c4_12_83_10, -1);
    check("idle drive", {io_oe_o, io_o}, 2'b11);
    t = 0;
    while (nu_cnt == 0 && t < 17000) begin
      @(posedge clock_i);
      t++;
    end
    check("wait byte pulse", nu_cnt, 1);
    wait_q(NULL_BYTE);
    check("within limit", i_term.last_gap < 960 * 16, 1'b1);
    check("reply kept", reply_due_o, 1'b1);
    card_send(8'h00, 1'b0);
    repeat (40) @(posedge clock_i);
    #1 check("frame drive", {io_oe_o, io_o}, 2'b11);
    wait_q(8'h00);
    $display("test inverse done");
    end_sim();
  end

endmodule : cit0_link_dev_tb_top
`default_nettype wire

// file: cit0_pkg.sv
// Constants and types for the card-side single-wire character link
package cit0_pkg;

  // Line controller states
  typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_TX} cit0_state_e;

  // Frame points in half-etu ticks counted from the start edge
  localparam logic [4:0]  H_CONFIRM    = 5'h01; // Start bit confirmed at 0.5 etu
  localparam logic [4:0]  H_FIRST_DATA = 5'h03; // First data sample at 1.5 etu
  localparam logic [4:0]  H_LAST_BIT   = 5'h13; // Parity sampled at 9.5 etu
  localparam logic [4:0]  H_GUARD      = 5'h14; // End of the ten-bit frame, 10 etu
  localparam logic [4:0]  H_ERR_ON     = 5'h15; // Error pulse starts at 10.5 etu
  localparam logic [4:0]  H_TX_CHECK   = 5'h16; // Transmitter looks for error at 11 etu
  localparam logic [4:0]  H_RX_DONE    = 5'h16; // Clean reception ends at 11 etu
  localparam logic [4:0]  H_ERR_OFF    = 5'h18; // Error pulse released at 12 etu
  localparam logic [4:0]  H_CHAR_GAP   = 5'h18; // 12 etu between start edges
  localparam logic [4:0]  H_RETRY_GAP  = 5'h1c; // Repeat starts 14 etu after the failed one
  localparam logic [4:0]  H_SAT        = 5'h1f; // Gap counter saturates here

  // Command layer
  localparam logic [2:0]  HEADER_LEN   = 3'h5;  // Bytes in a command header
  localparam logic [2:0]  INSTR_POS    = 3'h1;  // Header position of the instruction byte
  localparam logic [7:0]  NULL_BYTE    = 8'h60; // Wait procedure byte

  // Work waiting limit: 960 * wait_integer * clock_rate_factor card clocks,
  // i.e. 960 * wait_integer * baud_rate_factor etu, here in half etu
  localparam logic [24:0] WAIT_HALF_PER_UNIT = 25'h000780; // 2 * 960

  // Values after reset and default rates
  localparam logic [11:0] DEF_CLOCK_RATE = 12'h174; // 372
  localparam logic [5:0]  DEF_BAUD_RATE  = 6'h01;
  localparam logic [7:0]  DEF_WAIT_INT   = 8'h0a;   // 10
  localparam logic [11:0] RST_ACC        = 12'h000;
  localparam logic [24:0] RST_WAIT       = 25'h0000000;

  // Default margin, in etu, before the limit at which a wait byte is inserted
  localparam int          DEF_NULL_MARGIN_ETU = 32;

endpackage : cit0_pkg

// file: cit0_term_model.sv
// Terminal-side model of the single-wire character link, open drain with pull-up
`timescale 1ns/100ps
`default_nettype none
module cit0_term_model #(
  parameter int ETU = 8
) (
  input  wire logic clock_i,
  input  wire logic line_i,
  input  wire logic inverse_i,
  output logic      drv_low_o
);
  logic       busy      = 1'b0;
  logic       nack_next = 1'b0;
  logic       hold_low  = 1'b0;
  logic       tx_low    = 1'b0;
  logic       rx_low    = 1'b0;
  logic       err_seen;
  int         t_now     = 0;
  int         t_last    = 0;
  int         last_gap  = 0;
  int         err_low   = 0;
  int         par_bad   = 0;
  logic [7:0] rxq[$];

  // Open drain: the model can only pull the line low
  assign drv_low_o = tx_low | rx_low | hold_low;

  // Free cycle count for start edge spacing
  always @(posedge clock_i) begin
    t_now <= t_now + 1;
  end

  // Line levels of one frame, index 0 is the start bit
  function automatic logic [9:0] frame(input logic [7:0] b, input logic bad);
    logic [9:0] f;
    logic       p;
    p = ^b ^ bad;
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++) f[i+1] = inverse_i ? ~b[7-i] : b[i];
    f[9] = inverse_i ? ~p : p;
    return f;
  endfunction : frame

  // Send one character, repeat it with good parity when the card flags an error
  task automatic send_char(input logic [7:0] b, input logic bad);
    logic [9:0] f;
    int         low_n;
    int         gap;
    busy = 1'b1;
    gap = 12 * ETU;
    do begin
      f = frame(b, bad);
      // Line high and start edges spaced; a repeat waits 14 etu from the flagged start
      while (line_i !== 1'b1 || t_now - t_last < gap) @(posedge clock_i);
      last_gap = t_now - t_last;
      t_last = t_now;
      for (int k = 0; k < 10; k++) begin
        tx_low <= ~f[k];
        repeat (ETU) @(posedge clock_i);
      end
      tx_low <= 1'b0;
      low_n = 0;
      // Window 10..13 etu measures the error pulse, sampled at about 11 etu
      for (int k = 0; k < 3 * ETU; k++) begin
        @(posedge clock_i);
        if (line_i === 1'b0) low_n++;
        if (k == ETU) err_seen = (line_i === 1'b0);
      end
      // Keep the last pulse length so a clean repeat does not wipe it
      if (low_n > 0) err_low = low_n;
      bad = 1'b0;
      gap = 14 * ETU;
    end while (err_seen);
    busy = 1'b0;
  endtask : send_char

  // Receive card characters; a requested nack pulls the line for 1.5 etu
  always begin : rx_proc
    logic [8:0] s;
    logic [7:0] b;
    @(posedge clock_i);
    if (!busy && line_i === 1'b0) begin
      last_gap = t_now - t_last;
      t_last = t_now;
      repeat (ETU / 2) @(posedge clock_i);
      // A low gone within half an etu is a glitch, not a start bit
      if (line_i === 1'b0) begin
        for (int k = 0; k < 9; k++) begin
          repeat (ETU) @(posedge clock_i);
          s[k] = line_i;
        end
        for (int i = 0; i < 8; i++) b[i] = inverse_i ? ~s[7-i] : s[i];
        if ((^b) !== (inverse_i ? ~s[8] : s[8])) par_bad++;
        repeat (ETU) @(posedge clock_i);
        if (nack_next) begin
          nack_next = 1'b0;
          rx_low <= 1'b1;
          repeat (ETU + ETU / 2) @(posedge clock_i);
          rx_low <= 1'b0;
        end else begin
          rxq.push_back(b);
        end
      end
    end
  end

endmodule : cit0_term_model
`default_nettype wire

// file: placeholder_end.sv
// Empty unit kept for ordering; holds no logic
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire
